// [shared/lcddc_pkg.sv]
// lcddc_pkg: constants shared by the lcd display-control block
package lcddc_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   // control register field positions
   localparam int CTRL_RSVD = 7;    // reads as one
   localparam int CTRL_PWR_SW = 6;
   localparam int CTRL_ACTIVATE = 5;
   localparam int CTRL_DATA_SEL = 4;
   localparam int CTRL_CKS_HI = 3;
   localparam int CTRL_CKS_LO = 0;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // status register field positions
   localparam int STAT_SUB = 0;
   localparam int STAT_PHASE = 1;
   localparam int STAT_STALL = 2;
   localparam int STAT_CNT_LO = 4;
   localparam int STAT_CNT_HI = 12;
   // ------------------------------------------------------------
   // clock and frame timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int SUB_HZ = 32_768;
   // ticks per frame for subclock and system-clock sources
   localparam int FRAME_SUB = 256;
   localparam int FRAME_SYS = 512;
   localparam int NOM_FRAME_HZ = SUB_HZ / FRAME_SUB;  // 128 Hz
   // one-third duty shortens the frame to three quarters
   localparam logic [8:0] LAST_SUB = 9'(FRAME_SUB - 1);
   localparam logic [8:0] LAST_SUB3 = 9'(FRAME_SUB * 3 / 4 - 1);
   localparam logic [8:0] LAST_SYS = 9'(FRAME_SYS - 1);
   localparam logic [8:0] LAST_SYS3 = 9'(FRAME_SYS * 3 / 4 - 1);
   localparam int SEG_W = 32;
endpackage : lcddc_pkg

// [rtl/lcddc_top.sv]
// lcddc_top: lcd display control, frame clock select and apb slave
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - activate low halts all frame timing; high lets it run
// - activate low forces drive power off regardless of power switch
// - halting leaves every control register bit untouched
// - data select low drives blank segments; high drives display ram while activate is high
// - top select low uses subclock, undivided, half or quarter
// - top select high uses system clock divided by two up to 256
// - system clock sources stop frame timing in subclock power modes
// - one-third duty makes the frame four thirds as fast
// - undivided 32.768 kHz subclock yields a 128 Hz frame
// - standby forces drive power off regardless of power switch
module lcddc_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // subclock pin and power-mode status
   input wire logic sub_clk_in,
   input wire logic sub_power_mode,
   input wire logic standby_mode,
   input wire logic duty_third,
   // display ram data
   input wire logic [lcddc_pkg::SEG_W-1:0] ram_data,
   // panel side
   output logic [lcddc_pkg::SEG_W-1:0] seg_data,
   output logic lcd_power_on,
   output logic ctrl_running,
   output logic frame_pulse,
   output logic frame_phase
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic pwr_sw_r;
   logic activate_r;
   logic data_sel_r;
   logic [3:0] cks_r;
   logic sub_s1_r;
   logic sub_s2_r;
   logic sub_s3_r;
   logic [7:0] presc_r;
   logic [1:0] sub_cnt_r;
   logic [8:0] frame_cnt_r;
   logic [8:0] frame_cnt_nxt;
   logic frame_end;
   logic [lcddc_pkg::SEG_W-1:0] seg_r;
   logic power_r;
   logic run_r;
   logic pulse_r;
   logic phase_r;
   logic sub_edge;
   logic sys_tick;
   logic sub_tick;
   logic op_tick;
   logic src_sub;
   logic stall;
   logic acc_start;
   logic wr_en;
   logic [31:0] rd_mux;
   logic [8:0] last_cnt;

   // ------------------------------------------------------------
   // helper decoders
   // ------------------------------------------------------------
   // mask of prescaler bits for a system divide of 2 to 256
   function automatic logic [7:0] sys_mask(input logic [2:0] sel);
      sys_mask = 8'hff >> (3'h7 - sel);
   endfunction : sys_mask

   // mask of subclock edge counter for divide by 1, 2 or 4
   function automatic logic [1:0] sub_mask(input logic [1:0] sel);
      logic [1:0] m;
      m = 2'h0;
      if (sel[1]) begin
         m = 2'h3;
      end else if (sel[0]) begin
         m = 2'h1;
      end
      sub_mask = m;
   endfunction : sub_mask

   // last tick count of a frame for source and duty
   function automatic logic [8:0] frame_last(input logic sub, input logic third);
      logic [8:0] l;
      l = lcddc_pkg::LAST_SYS;
      if (sub && third) begin
         l = lcddc_pkg::LAST_SUB3;
      end else if (sub) begin
         l = lcddc_pkg::LAST_SUB;
      end else if (third) begin
         l = lcddc_pkg::LAST_SYS3;
      end
      frame_last = l;
   endfunction : frame_last

   // ------------------------------------------------------------
   // apb handshake
   // ------------------------------------------------------------
   assign acc_start = psel && penable && !pready_r;
   assign wr_en = psel && penable && pready_r && pwrite;

   // one wait state, ready pulses high for one cycle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= acc_start;
      end
   end

   // read data and error captured on the same edge that raises ready
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (acc_start) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_r <= (paddr != lcddc_pkg::ADDR_CTRL) &&
                      (paddr != lcddc_pkg::ADDR_STAT);
      end else if (pready_r) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
   end

   // read multiplexer, unused bits read zero except reserved control bit 7, which reads one
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == lcddc_pkg::ADDR_CTRL) begin
         rd_mux[lcddc_pkg::CTRL_RSVD] = 1'b1;
         rd_mux[lcddc_pkg::CTRL_PWR_SW] = pwr_sw_r;
         rd_mux[lcddc_pkg::CTRL_ACTIVATE] = activate_r;
         rd_mux[lcddc_pkg::CTRL_DATA_SEL] = data_sel_r;
         rd_mux[lcddc_pkg::CTRL_CKS_HI:lcddc_pkg::CTRL_CKS_LO] = cks_r;
      end else if (paddr == lcddc_pkg::ADDR_STAT) begin
         rd_mux[lcddc_pkg::STAT_SUB] = src_sub;
         rd_mux[lcddc_pkg::STAT_PHASE] = phase_r;
         rd_mux[lcddc_pkg::STAT_STALL] = stall;
         rd_mux[lcddc_pkg::STAT_CNT_HI:lcddc_pkg::STAT_CNT_LO] = frame_cnt_r;
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   // reset to zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         {pwr_sw_r, activate_r, data_sel_r, cks_r} <= lcddc_pkg::CTRL_RESET;
      end else if (wr_en && paddr == lcddc_pkg::ADDR_CTRL) begin
         pwr_sw_r <= pwdata[lcddc_pkg::CTRL_PWR_SW];
         activate_r <= pwdata[lcddc_pkg::CTRL_ACTIVATE];
         data_sel_r <= pwdata[lcddc_pkg::CTRL_DATA_SEL];
         cks_r <= pwdata[lcddc_pkg::CTRL_CKS_HI:lcddc_pkg::CTRL_CKS_LO];
      end
   end

   // ------------------------------------------------------------
   // subclock synchroniser
   // ------------------------------------------------------------
   // two flops then an edge-detect flop
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sub_s1_r <= 1'b0;
         sub_s2_r <= 1'b0;
         sub_s3_r <= 1'b0;
      end else begin
         sub_s1_r <= sub_clk_in;
         sub_s2_r <= sub_s1_r;
         sub_s3_r <= sub_s2_r;
      end
   end

   assign sub_edge = sub_s2_r && !sub_s3_r;

   // ------------------------------------------------------------
   // operating clock selection
   // ------------------------------------------------------------
   assign src_sub = !cks_r[3];
   assign stall = sub_power_mode && !src_sub;

   // free-running system prescaler, cleared while halted
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !activate_r || stall) begin
         presc_r <= 8'h00;
      end else begin
         presc_r <= presc_r + 8'h01;
      end
   end

   assign sys_tick = (presc_r & sys_mask(cks_r[2:0])) == sys_mask(cks_r[2:0]);

   // subclock edge counter for the half and quarter rates
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !activate_r) begin
         sub_cnt_r <= 2'h0;
      end else if (sub_edge) begin
         sub_cnt_r <= sub_cnt_r + 2'h1;
      end
   end

   assign sub_tick = sub_edge &&
                     ((sub_cnt_r & sub_mask(cks_r[1:0])) == sub_mask(cks_r[1:0]));

   assign op_tick = activate_r && (src_sub ? sub_tick : (sys_tick && !stall));

   // ------------------------------------------------------------
   // frame timing
   // ------------------------------------------------------------
   // shorter third-duty frame
   assign last_cnt = frame_last(src_sub, duty_third);
   assign frame_end = op_tick && (frame_cnt_r >= last_cnt);

   always_comb begin
      frame_cnt_nxt = frame_cnt_r;
      if (frame_end) begin
         frame_cnt_nxt = 9'h000;
      end else if (op_tick) begin
         frame_cnt_nxt = frame_cnt_r + 9'h001;
      end
   end

   // frame counter, cleared while halted
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !activate_r) begin
         frame_cnt_r <= 9'h000;
      end else begin
         frame_cnt_r <= frame_cnt_nxt;
      end
   end

   // frame pulse and alternating drive phase
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !activate_r) begin
         pulse_r <= 1'b0;
         phase_r <= 1'b0;
      end else begin
         pulse_r <= frame_end;
         if (frame_end) begin
            phase_r <= !phase_r;
         end
      end
   end

   // ------------------------------------------------------------
   // panel outputs
   // ------------------------------------------------------------
   // blank or ram data
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         seg_r <= '0;
      end else if (activate_r && data_sel_r) begin
         seg_r <= ram_data;
      end else begin
         seg_r <= '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         power_r <= 1'b0;
      end else begin
         power_r <= activate_r && pwr_sw_r && !standby_mode;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         run_r <= 1'b0;
      end else begin
         run_r <= activate_r && !stall;
      end
   end

   // ------------------------------------------------------------
   // output drive
   // ------------------------------------------------------------
   assign pready = pready_r;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign seg_data = seg_r;
   assign lcd_power_on = power_r;
   assign ctrl_running = run_r;
   assign frame_pulse = pulse_r;
   assign frame_phase = phase_r;

endmodule : lcddc_top

`default_nettype wire

// [verif/lcddc_checker.sv]
// lcddc_checker: port assertions for the lcd display control block
`timescale 1ns/1ps
`default_nettype none
module lcddc_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // apb and mode inputs
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic sub_power_mode,
   input wire logic standby_mode,
   input wire logic [lcddc_pkg::SEG_W-1:0] ram_data,
   // panel outputs
   input wire logic [lcddc_pkg::SEG_W-1:0] seg_data,
   input wire logic lcd_power_on,
   input wire logic ctrl_running,
   input wire logic frame_pulse,
   input wire logic frame_phase
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // halted for three cycles, with or without stall
   sequence s_stop3; !ctrl_running [*3]; endsequence
   sequence s_idle3; (!ctrl_running && !sub_power_mode) [*3]; endsequence
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_err_unmapped: assert property (pslverr |-> pready &&
      paddr != lcddc_pkg::ADDR_CTRL && paddr != lcddc_pkg::ADDR_STAT)
      else $error("bad error");
   a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("stray data");
   a_seg_source: assert property (seg_data != '0 |-> seg_data == $past(ram_data))
      else $error("segment data wrong");
   a_power_stby: assert property (standby_mode |=> !lcd_power_on)
      else $error("power on in standby");
   a_power_act: assert property (lcd_power_on && !$past(sub_power_mode) |-> ctrl_running)
      else $error("power without activate");
   a_halt_quiet: assert property (s_stop3 |-> !frame_pulse)
      else $error("frame while halted");
   a_phase_clear: assert property (s_idle3 |-> !frame_phase)
      else $error("phase kept while halted");
   a_pulse_one: assert property (frame_pulse |=> !frame_pulse [*8])
      else $error("frame too short");
endmodule : lcddc_checker
bind lcddc_top lcddc_checker lcddc_checker_i (.clk_sys, .sys_rst, .psel, .penable, .paddr,
   .pready, .prdata, .pslverr, .sub_power_mode, .standby_mode, .ram_data, .seg_data,
   .lcd_power_on, .ctrl_running, .frame_pulse, .frame_phase);
`default_nettype wire

// [verif/lcddc_panel.sv]
// lcddc_panel: panel model that times frames and shows driven segments
`timescale 1ns/1ps
`default_nettype none
module lcddc_panel (
   // clock
   input wire logic clk_sys,
   // drive from the controller
   input wire logic frame_pulse,
   input wire logic lcd_power_on,
   input wire logic [lcddc_pkg::SEG_W-1:0] seg_data,
   // measurements
   output int frames,
   output int period,
   output logic [lcddc_pkg::SEG_W-1:0] shown
);
   int cnt = 0;
   always @(posedge clk_sys) begin
      cnt <= frame_pulse ? 1 : cnt + 1;
      if (frame_pulse) begin
         frames <= frames + 1;
         period <= cnt;
      end
   end
   // segments are visible only with drive power applied
   assign shown = lcd_power_on ? seg_data : '0;
   initial frames = 0;
endmodule : lcddc_panel
`default_nettype wire

// [verif/lcddc_top_tb.sv]
// lcddc_top_tb: self-checking bench for the lcd display control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module lcddc_top_tb;
   logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, sub_clk_in = 0, sub_power_mode = 0, standby_mode = 0;
   logic duty_third = 0, lcd_power_on, ctrl_running, frame_pulse, frame_phase;
   logic [lcddc_pkg::SEG_W-1:0] ram_data = 32'h5a3c_96e1, seg_data, shown;
   int err_total = 0, n_compared = 0, frames, period, sub_div = 0;
   // clock and an eight-cycle subclock
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      sub_div <= sub_div + 1;
      sub_clk_in <= sub_div[2];
   end
   lcddc_top lcddc_top_i (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .sub_clk_in, .sub_power_mode, .standby_mode, .duty_third,
      .ram_data, .seg_data, .lcd_power_on, .ctrl_running, .frame_pulse, .frame_phase);
   lcddc_panel lcddc_panel_i (.clk_sys, .frame_pulse, .lcd_power_on, .seg_data, .frames,
      .period, .shown);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   // one apb transfer, waiting on pready with a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         $display("ERROR apb_ready expected 1 seen %0b", pready);
         err_total++;
         final_report();
      end
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic t_reset();
      apb(0, 8'h00, '0); `CHK("ctrl", 32'h80, rd)
      apb(0, 8'h04, '0); `CHK("stat", 32'h1, rd)
      apb(0, 8'h08, '0); `CHK("slverr", 1'b1, er)
   endtask : t_reset
   task automatic t_ctrl();
      apb(1, 8'h00, 32'h5f);
      repeat (2) @(negedge clk_sys); `CHK("power_off", 1'b0, lcd_power_on)
      apb(0, 8'h00, '0); `CHK("kept", 32'hdf, rd)
      apb(1, 8'h00, 32'h60);
      repeat (2) @(negedge clk_sys); `CHK("power_on", 1'b1, lcd_power_on)
      @(posedge clk_sys) standby_mode <= 1;
      repeat (2) @(negedge clk_sys); `CHK("stby_off", 1'b0, lcd_power_on)
      @(posedge clk_sys) standby_mode <= 0;
   endtask : t_ctrl
   task automatic t_blank();
      @(negedge clk_sys); `CHK("blank", 32'h0, seg_data)
      apb(1, 8'h00, 32'h70);
      @(posedge clk_sys) ram_data <= ~ram_data;
      repeat (2) @(negedge clk_sys); `CHK("shown", ram_data, shown)
   endtask : t_blank
   task automatic t_frame(input logic [3:0] c, input logic dt, input int ex);
      int k, n;
      @(posedge clk_sys) duty_third <= dt;
      apb(1, 8'h00, 32'h40);
      apb(1, 8'h00, {24'h0, 4'h6, c});
      k = frames + 2;
      for (n = 0; n < 3 * ex && frames < k; n++) @(posedge clk_sys);
      if (frames < k) begin
         $display("ERROR frame wait expected %0d seen %0d", k, frames);
         err_total++;
         final_report();
      end
      `CHK("period", ex, period)
   endtask : t_frame
   task automatic t_stall();
      int k;
      apb(1, 8'h00, 32'h68);
      @(posedge clk_sys) sub_power_mode <= 1;
      k = frames;
      repeat (3000) @(negedge clk_sys);
      `CHK("stall_frames", k, frames)
      `CHK("stall_run", 1'b0, ctrl_running)
      apb(1, 8'h00, 32'h60);
      repeat (5000) @(negedge clk_sys);
      `CHK("sub_run", 1'b1, frames > k)
      @(posedge clk_sys) sub_power_mode <= 0;
   endtask : t_stall
   // reset again in mid-run, settings must return to their reset values
   task automatic t_rerun();
      @(posedge clk_sys) sys_rst <= 1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 0;
      @(negedge clk_sys); `CHK("rst_power", 1'b0, lcd_power_on)
      apb(0, 8'h00, '0); `CHK("rst_ctrl", 32'h80, rd)
   endtask : t_rerun
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 0;
      t_reset();
      t_ctrl();
      t_blank();
      t_frame(4'h0, 0, 2048);
      t_frame(4'h1, 0, 4096);
      t_frame(4'h6, 0, 8192);
      t_frame(4'h8, 0, 1024);
      t_frame(4'h9, 0, 2048);
      t_frame(4'ha, 0, 4096);
      t_frame(4'h0, 1, 1536);
      t_frame(4'h8, 1, 768);
      t_stall();
      t_rerun();
      final_report();
   end
endmodule : lcddc_top_tb
`default_nettype wire
